/* hw/pir_axil_slave.sv */
// AXI4-Lite slave front end: turns bus transfers into one-cycle register requests.
// Assumes the owner decodes the read address combinationally and checks write addresses.
module pir_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pir_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] rd_data,
	input wire logic rd_err,
	input wire logic wr_err,
	output logic wr_valid,
	output pir_pkg::pir_wr_s wr
);
	import pir_pkg::*;

	logic aw_full;
	logic w_full;
	logic [31:0] lane_mask;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_wr = aw_full & w_full & ~s_axi_bvalid;

	// Unstrobed lanes are zeroed; every write here acts on ones only
	assign lane_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign wr_valid = do_wr;

	// ----------------------------------------------------------------
	// Write channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			wr <= '0;
		end else begin
			if (aw_take) begin
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
				wr.addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
				wr.data <= s_axi_wdata & lane_mask;
			end
			if (do_wr) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

/* hw/pir_pkg.sv */
// Constants, types and the register map of the peripheral interrupt routing block.
// Assumes one 200 MHz clock and event pulses from peripheral logic on that clock.
package pir_pkg;

	localparam int NUM_LINES = 25;
	localparam int SRC_W = 8;
	localparam int ADDR_W = 12;
	localparam int NUM_SERIAL = 6;
	localparam int NUM_TIMER = 8;

	// ----------------------------------------------------------------
	// Line numbers toward the core controller
	// ----------------------------------------------------------------
	localparam int LINE_POWER = 0;
	localparam int LINE_SYSTEM_CONTROL_UNIT = 1;
	localparam int LINE_WATCHDOG = 2;
	localparam int LINE_RTC = 3;
	localparam int LINE_EXTIRQ = 4;
	localparam int LINE_NVM = 5;
	localparam int LINE_EVENT_SYSTEM = 6;
	localparam int LINE_SERIAL0 = 7;
	localparam int LINE_TIMER0 = 13;
	localparam int LINE_ADC = 21;
	localparam int LINE_ACMP = 22;
	localparam int LINE_DAC = 23;
	localparam int LINE_TOUCH = 24;

	// ----------------------------------------------------------------
	// Register map: one 16-byte slot per line, slot index = line number
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_EN_CLR = 4'h0;
	localparam logic [3:0] OFS_EN_SET = 4'h4;
	localparam logic [3:0] OFS_FLAGS = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_NMI_FLAG = 12'h190;
	localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 12'h1a0;
	localparam logic [SRC_W-1:0] RST_FLAGS = 8'h00;
	localparam logic [SRC_W-1:0] RST_ENABLES = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef logic [SRC_W-1:0] pir_src_t;

	typedef struct packed {
		pir_src_t power;
		pir_src_t system_control_unit;
		pir_src_t watchdog;
		pir_src_t rtc;
		pir_src_t extirq;
		logic extirq_nmi;
		pir_src_t nvm;
		pir_src_t event_system;
		pir_src_t [NUM_SERIAL-1:0] serial;
		pir_src_t [NUM_TIMER-1:0] timer;
		pir_src_t adc;
		pir_src_t acmp;
		pir_src_t dac;
		pir_src_t touch;
	} pir_events_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
	} pir_wr_s;

endpackage

/* hw/pir_source_bank.sv */
// Flag and enable bits of one peripheral, with its single combined request.
// Assumes event pulses and write masks arrive on aclk, one cycle each.
module pir_source_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire pir_pkg::pir_src_t event_in,
	input wire pir_pkg::pir_src_t flag_clr,
	input wire pir_pkg::pir_src_t en_set,
	input wire pir_pkg::pir_src_t en_clr,
	output pir_pkg::pir_src_t flags,
	output pir_pkg::pir_src_t enables,
	output logic request
);
	import pir_pkg::*;

	pir_src_t next_flags;
	pir_src_t next_enables;

	// Event set wins over a flag clear in the same cycle so no event is lost; enable clear wins over enable set
	assign next_flags = (flags & ~flag_clr) | event_in;
	assign next_enables = (enables | en_set) & ~en_clr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= RST_FLAGS;
			enables <= RST_ENABLES;
			request <= 1'b0;
		end else begin
			flags <= next_flags;
			enables <= next_enables;
			request <= |(flags & enables);
		end
	end

endmodule

/* hw/pir_top.sv */
// Peripheral interrupt routing: per-peripheral flags and enables, one request line each,
// and the fixed line numbering toward the core interrupt controller.
// Assumes peripheral events are one-cycle pulses on aclk; the core controller
// does its own pending, line enable and priority handling on irq_lines.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
module pir_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire pir_pkg::pir_events_s events,
	output logic [pir_pkg::NUM_LINES-1:0] irq_lines,
	output logic core_nmi,
	input wire logic [pir_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pir_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import pir_pkg::*;

	// ----------------------------------------------------------------
	// Source events gathered by line number
	// ----------------------------------------------------------------
	pir_src_t line_events [NUM_LINES];

	assign line_events[LINE_POWER] = events.power;
	assign line_events[LINE_SYSTEM_CONTROL_UNIT] = events.system_control_unit;
	assign line_events[LINE_WATCHDOG] = events.watchdog;
	assign line_events[LINE_RTC] = events.rtc;
	assign line_events[LINE_EXTIRQ] = events.extirq;
	assign line_events[LINE_NVM] = events.nvm;
	assign line_events[LINE_EVENT_SYSTEM] = events.event_system;

	genvar s;
	generate
		for (s = 0; s < NUM_SERIAL; s++) begin : g_serial
			assign line_events[LINE_SERIAL0 + s] = events.serial[s];
		end
		for (s = 0; s < NUM_TIMER; s++) begin : g_timer
			assign line_events[LINE_TIMER0 + s] = events.timer[s];
		end
	endgenerate

	assign line_events[LINE_ADC] = events.adc;
	assign line_events[LINE_ACMP] = events.acmp;
	assign line_events[LINE_DAC] = events.dac;
	assign line_events[LINE_TOUCH] = events.touch;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	logic wr_valid;
	pir_wr_s wr;
	logic [31:0] rd_data;
	logic rd_err;
	logic wr_err;

	pir_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rd_data(rd_data),
		.rd_err(rd_err),
		.wr_err(wr_err),
		.wr_valid(wr_valid),
		.wr(wr)
	);

	// ----------------------------------------------------------------
	// Write address decode
	// ----------------------------------------------------------------
	// Slot index is address bits 8:4; the top bits must be clear
	wire [4:0] wr_slot = wr.addr[8:4];
	wire [3:0] wr_ofs = wr.addr[3:0];
	wire wr_in_lines = (wr.addr[ADDR_W-1:9] == 3'h0) && (wr_slot < 5'(NUM_LINES));
	wire wr_ofs_ok = (wr_ofs == OFS_EN_CLR) || (wr_ofs == OFS_EN_SET) || (wr_ofs == OFS_FLAGS);
	wire wr_line_hit = wr_in_lines && wr_ofs_ok;
	wire wr_nmi_hit = (wr.addr == ADDR_NMI_FLAG);
	wire wr_status_hit = (wr.addr == ADDR_LINE_STATUS);

	// The status word is read-only; a write to it is refused with an error
	assign wr_err = !(wr_line_hit || wr_nmi_hit) || wr_status_hit;

	wire wr_line_go = wr_valid && wr_line_hit;
	wire pir_src_t wr_bits = wr.data[SRC_W-1:0];

	// ----------------------------------------------------------------
	// One flag and enable bank per line
	// ----------------------------------------------------------------
	pir_src_t flags_arr [NUM_LINES];
	pir_src_t enables_arr [NUM_LINES];
	logic [NUM_LINES-1:0] line_req;

	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_line
			wire slot_hit = wr_line_go && (wr_slot == 5'(g));
			wire pir_src_t clr_mask = (slot_hit && wr_ofs == OFS_FLAGS) ? wr_bits : '0;
			wire pir_src_t set_mask = (slot_hit && wr_ofs == OFS_EN_SET) ? wr_bits : '0;
			wire pir_src_t off_mask = (slot_hit && wr_ofs == OFS_EN_CLR) ? wr_bits : '0;

			pir_source_bank u_bank (
				.aclk(aclk),
				.aresetn(aresetn),
				.event_in(line_events[g]),
				.flag_clr(clr_mask),
				.en_set(set_mask),
				.en_clr(off_mask),
				.flags(flags_arr[g]),
				.enables(enables_arr[g]),
				.request(line_req[g])
			);
		end
	endgenerate

	// Each bank's request is already a flip-flop
	assign irq_lines = line_req;

	// ----------------------------------------------------------------
	// Non-maskable source
	// ----------------------------------------------------------------
	// Has no enable: once flagged it reaches the core until software clears it
	logic next_nmi;
	wire nmi_clr = wr_valid && wr_nmi_hit && wr.data[0];

	assign next_nmi = (core_nmi && !nmi_clr) || events.extirq_nmi;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_nmi <= 1'b0;
		end else begin
			core_nmi <= next_nmi;
		end
	end

	// ----------------------------------------------------------------
	// Read address decode
	// ----------------------------------------------------------------
	wire [4:0] rd_slot = s_axi_araddr[8:4];
	wire [3:0] rd_ofs = s_axi_araddr[3:0];
	wire rd_in_lines = (s_axi_araddr[ADDR_W-1:9] == 3'h0) && (rd_slot < 5'(NUM_LINES));
	wire rd_en_hit = rd_in_lines && ((rd_ofs == OFS_EN_CLR) || (rd_ofs == OFS_EN_SET));
	wire rd_flag_hit = rd_in_lines && (rd_ofs == OFS_FLAGS);
	wire rd_nmi_hit = (s_axi_araddr == ADDR_NMI_FLAG);
	wire rd_status_hit = (s_axi_araddr == ADDR_LINE_STATUS);
	wire [4:0] rd_idx = rd_in_lines ? rd_slot : 5'h00;

	// Both enable registers read back the current enable bits
	assign rd_data = rd_en_hit ? {24'h000000, enables_arr[rd_idx]} :
		rd_flag_hit ? {24'h000000, flags_arr[rd_idx]} :
		rd_nmi_hit ? {31'h0000_0000, core_nmi} :
		rd_status_hit ? {7'h00, line_req} :
		32'h0000_0000;
	assign rd_err = !(rd_en_hit || rd_flag_hit || rd_nmi_hit || rd_status_hit);

endmodule

/* tb/pir_core_model.sv */
// Model of the core interrupt controller that receives the request lines.
// Assumes levels on aclk; its software-side controls come from the bench.
module pir_core_model
	import pir_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pir_pkg::NUM_LINES-1:0] irq_lines,
	input wire logic [pir_pkg::NUM_LINES-1:0] line_en,
	input wire logic [pir_pkg::NUM_LINES-1:0] pend_clr,
	output logic [pir_pkg::NUM_LINES-1:0] pending,
	output logic [pir_pkg::NUM_LINES-1:0] active
);
	logic [31:0] priority_regs [8];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= '0;
			for (int i = 0; i < 8; i++) priority_regs[i] <= '0;
		end else begin
			pending <= (pending & ~pend_clr) | irq_lines;
		end
	end
	assign active = pending & line_en;
endmodule

/* tb/pir_top_chk.sv */
// Checker on the routing top ports: request lines, NMI and bus handshakes.
// Assumes it is bound into pir_top; one clock, synchronous active-low reset.
module pir_top_chk
	import pir_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire pir_pkg::pir_events_s events,
	input wire logic [pir_pkg::NUM_LINES-1:0] irq_lines,
	input wire logic core_nmi,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// -----------------------------------------
	// Assertions
	// -----------------------------------------
	// A clear or disable lands two edges after the write handshake, while awready is low
	a_lines_sticky: assert property (
		s_axi_awready && $past(s_axi_awready) |=> (irq_lines & $past(irq_lines)) == $past(irq_lines))
		else $error("request line dropped with no write");
	a_no_stray_rise: assert property (
		events == '0 && $past(events) == '0 && s_axi_awready |=> (irq_lines & ~$past(irq_lines)) == '0)
		else $error("request line rose with no cause");
	a_nmi_sets: assert property (events.extirq_nmi |=> core_nmi)
		else $error("nmi event not seen");
	a_nmi_cause: assert property ($rose(core_nmi) |-> $past(events.extirq_nmi))
		else $error("nmi rose with no event");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer mistimed");
	c_nmi: cover property (events.extirq_nmi ##1 core_nmi);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	c_top_line: cover property ($rose(irq_lines[24]));
endmodule

/* tb/pir_top_tb.sv */
// Self-checking bench for the routing top: bus tasks, event pulses, one task per scenario.
// Assumes the checker is bound below and the core model watches the request lines.
module pir_top_tb
	import pir_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	pir_events_s events = '0;
	logic [NUM_LINES-1:0] irq_lines, pending, active;
	logic [NUM_LINES-1:0] line_en = 25'h1555555;
	logic [NUM_LINES-1:0] pend_clr = '0;
	logic core_nmi, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	int n_mismatch = 0;
	int compares = 0;
	always #2.5 aclk = ~aclk;
	pir_top u_dut (.aclk(aclk), .aresetn(aresetn), .events(events), .irq_lines(irq_lines), .core_nmi(core_nmi),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	pir_core_model u_core (.aclk(aclk), .aresetn(aresetn), .irq_lines(irq_lines), .line_en(line_en),
		.pend_clr(pend_clr), .pending(pending), .active(active));
	// -----------------------------------------
	// Compare, bus and stimulus tasks
	// -----------------------------------------
	task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: want %h got %h", $time, exp, got);
		end
	endtask
	// Lines change just after a clock edge, so they are looked at on the falling edge
	task automatic cmp_lines(input logic [NUM_LINES-1:0] exp, ref logic [NUM_LINES-1:0] got);
		@(negedge aclk);
		cmp_word({7'h0, exp}, {7'h0, got});
	endtask
	task automatic tally_and_finish;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Ready for the answer goes up with the request; the answer is taken at the edge it is seen
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		cmp_word(32'(RESP_OKAY), 32'(r));
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		cmp_word(exp, d);
		cmp_word(32'(RESP_OKAY), 32'(r));
	endtask
	task automatic pulse(input pir_events_s e);
		@(posedge aclk);
		events <= e;
		@(posedge aclk);
		events <= '0;
		repeat (2) @(posedge aclk);
	endtask
	function automatic pir_events_s ev_for(input int ln, input int b);
		pir_events_s e;
		e = '0;
		case (ln)
			0: e.power[b] = 1'b1;
			1: e.system_control_unit[b] = 1'b1;
			2: e.watchdog[b] = 1'b1;
			3: e.rtc[b] = 1'b1;
			4: e.extirq[b] = 1'b1;
			5: e.nvm[b] = 1'b1;
			6: e.event_system[b] = 1'b1;
			21: e.adc[b] = 1'b1;
			22: e.acmp[b] = 1'b1;
			23: e.dac[b] = 1'b1;
			24: e.touch[b] = 1'b1;
			default: if (ln < 13) e.serial[ln-7][b] = 1'b1; else e.timer[ln-13][b] = 1'b1;
		endcase
		return e;
	endfunction
	function automatic logic [ADDR_W-1:0] slot(input int n, input logic [3:0] ofs);
		return ADDR_W'(n * 16) | {8'h00, ofs};
	endfunction
	// -----------------------------------------
	// Scenarios
	// -----------------------------------------
	task automatic t_reset;
		cmp_lines('0, irq_lines);
		cmp_word(32'h0, {31'h0, core_nmi});
		rd_chk(slot(3, OFS_EN_SET), 32'h0);
		rd_chk(slot(3, OFS_FLAGS), 32'h0);
	endtask
	task automatic t_mapping;
		int b;
		for (int n = 0; n < NUM_LINES; n++) begin
			b = n % 8;
			wr_ok(slot(n, OFS_EN_SET), 32'h1 << b);
			pulse(ev_for(n, b));
			cmp_lines(25'h1 << n, irq_lines);
			wr_ok(slot(n, OFS_FLAGS), 32'h1 << b);
			cmp_lines('0, irq_lines);
			cmp_lines(25'h1 << n, pending);
			cmp_lines((n % 2) ? 25'h0 : 25'h1 << n, active);
			wr_ok(slot(n, OFS_EN_CLR), 32'h1 << b);
			pend_clr <= '1;
			@(posedge aclk);
			pend_clr <= '0;
		end
	endtask
	task automatic t_gating;
		pulse(pir_events_s'(ev_for(13, 2) | ev_for(13, 5)));
		cmp_lines('0, irq_lines);
		rd_chk(slot(13, OFS_FLAGS), 32'h24);
		wr_ok(slot(13, OFS_FLAGS), 32'h0);
		rd_chk(slot(13, OFS_FLAGS), 32'h24);
		wr_ok(slot(13, OFS_EN_SET), 32'h4);
		cmp_lines(25'h1 << 13, irq_lines);
		wr_ok(slot(13, OFS_EN_SET), 32'h0);
		wr_ok(slot(13, OFS_EN_SET), 32'h20);
		rd_chk(slot(13, OFS_EN_CLR), 32'h24);
		wr_ok(slot(13, OFS_EN_CLR), 32'h4);
		rd_chk(slot(13, OFS_EN_SET), 32'h20);
		cmp_lines(25'h1 << 13, irq_lines);
		wr_ok(slot(13, OFS_FLAGS), 32'h20);
		cmp_lines('0, irq_lines);
		rd_chk(slot(13, OFS_FLAGS), 32'h4);
		wr_ok(slot(13, OFS_FLAGS), 32'h4);
		wr_ok(slot(13, OFS_EN_CLR), 32'h20);
	endtask
	task automatic t_nmi;
		pir_events_s e;
		e = '0;
		e.extirq_nmi = 1'b1;
		pulse(e);
		cmp_word(32'h1, {31'h0, core_nmi});
		cmp_lines('0, irq_lines);
		rd_chk(ADDR_NMI_FLAG, 32'h1);
		wr_ok(ADDR_NMI_FLAG, 32'h0);
		cmp_word(32'h1, {31'h0, core_nmi});
		wr_ok(ADDR_NMI_FLAG, 32'h1);
		cmp_word(32'h0, {31'h0, core_nmi});
	endtask
	task automatic t_errors;
		logic [31:0] d;
		logic [1:0] r;
		wr_ok(slot(24, OFS_EN_SET), 32'h80);
		pulse(ev_for(24, 7));
		rd_chk(ADDR_LINE_STATUS, 32'h1000000);
		wr(ADDR_LINE_STATUS, 32'h0, r);
		cmp_word(32'(RESP_SLVERR), 32'(r));
		cmp_lines(25'h1 << 24, irq_lines);
		rd(12'h1f0, d, r);
		cmp_word(32'(RESP_SLVERR), 32'(r));
		cmp_word(32'h0, d);
		wr_ok(slot(24, OFS_FLAGS), 32'h80);
		wr_ok(slot(24, OFS_EN_CLR), 32'h80);
		// Lane 0 unstrobed: its ones must act as zero bits
		s_axi_wstrb <= 4'he;
		wr_ok(slot(0, OFS_EN_SET), 32'hff);
		s_axi_wstrb <= 4'hf;
		rd_chk(slot(0, OFS_EN_SET), 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_mapping;
		t_gating;
		t_nmi;
		t_errors;
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		tally_and_finish;
	end
endmodule
bind pir_top pir_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .events(events), .irq_lines(irq_lines),
	.core_nmi(core_nmi), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
